// [tcm_consts.svh]
// Behaviour
// - Nonzero channel A mode field routes A waveform to pin instead of port.
// - Waveform drives pin only when port direction bit selects output.
// - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clear on match set at BOTTOM; 11 inverse.
// - Phase-correct A: 10 clear on up match, set on down; 11 inverse.
// - Phase-correct A code 01: waveform held on pin if high mode bit 0, else toggle.
// - Fast PWM, compare A equals TOP with upper bit: skip match, act at BOTTOM.
// - Phase-correct, compare A equals TOP with upper bit: skip match, act at TOP.
// - PWM, compare B equals TOP with upper bit: skip match, act at BOTTOM in fast PWM, at TOP in phase-correct.
// - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM B: 01 reserved; 10 clear match set BOTTOM; 11 inverse.
// - Phase-correct B: 01 reserved; 10 clear up match, set down; 11 inverse.
// - Control bits 3 and 2 read zero; software writes them zero.
// - Mode is high bit plus two low control bits; 4 and 6 reserved.
// - Modes 0 and 2: TOP 0xFF or compare A, immediate update, overflow at MAX.
// - Modes 1 and 5: TOP 0xFF or compare A, reload at TOP, overflow at BOTTOM.
// - Modes 3 and 7: reload at BOTTOM; overflow at MAX or at TOP.
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH
`define TCM_ADDR_CTRL_A 12'h024
`define TCM_ADDR_CTRL_B 12'h028
`define TCM_ADDR_CMP_A 12'h02C
`define TCM_ADDR_CMP_B 12'h030
`define TCM_ADDR_COUNT 12'h034
`define TCM_ADDR_STATUS 12'h038
`define TCM_ADDR_MASK 12'h03C
`define TCM_CTRL_A_RESET 8'h00
`define TCM_CTRL_A_WMASK 8'hF3
`define TCM_MAX 8'hFF
`define TCM_BOTTOM 8'h00
`define TCM_ST_OVF 0
`define TCM_ST_CMPA 1
`define TCM_ST_CMPB 2
`define TCM_ST_W 3
`endif

// [tcm_pkg.sv]
`default_nettype none
package tcm_pkg;
	typedef enum logic [2:0] {
		TCM_NORMAL = 3'd0, TCM_PC_FF = 3'd1, TCM_CTC = 3'd2, TCM_FAST_FF = 3'd3,
		TCM_RES4 = 3'd4, TCM_PC_CA = 3'd5, TCM_RES6 = 3'd6, TCM_FAST_CA = 3'd7
	} tcm_mode_e;
	typedef enum logic [1:0] {
		TCM_OFF = 2'd0, TCM_TOG = 2'd1, TCM_CLR = 2'd2, TCM_SET = 2'd3
	} tcm_out_mode_e;
endpackage
`default_nettype wire

// [tcm_timer.sv]
// The APB slave port is this design's own decision.
`include "tcm_consts.svh"
`default_nettype none
module tcm_timer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port direction bits for the two pins
	input wire logic dir_a_out,
	input wire logic dir_b_out,
	// Waveform pins
	output logic chan_a_wave_out,
	output logic chan_a_wave_oe,
	output logic chan_a_pin_override,
	output logic chan_b_wave_out,
	output logic chan_b_wave_oe,
	output logic chan_b_pin_override,
	// Interrupt
	output logic irq
);
	logic [7:0] ctrl_a_q;
	logic wave_mode_high_q;
	logic [2:0] clk_sel_q;
	logic [7:0] cmp_a_buf_q, cmp_b_buf_q, cmp_a_q, cmp_b_q, count_q;
	logic down_q;
	logic [`TCM_ST_W-1:0] status_q, mask_q;
	logic [9:0] presc_q;
	logic oa_q, ob_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	tcm_pkg::tcm_mode_e mode;
	assign mode = tcm_pkg::tcm_mode_e'({wave_mode_high_q, ctrl_a_q[1:0]});
	logic is_fast, is_pc, is_pwm, top_is_a;
	assign is_fast = mode == tcm_pkg::TCM_FAST_FF || mode == tcm_pkg::TCM_FAST_CA;
	assign is_pc = mode == tcm_pkg::TCM_PC_FF || mode == tcm_pkg::TCM_PC_CA;
	assign is_pwm = is_fast || is_pc;
	assign top_is_a = mode == tcm_pkg::TCM_CTC || mode == tcm_pkg::TCM_PC_CA || mode == tcm_pkg::TCM_FAST_CA;
	logic [7:0] top;
	assign top = top_is_a ? cmp_a_q : `TCM_MAX;

	// Prescaler tick
	logic tick;
	always_comb begin
		unique case (clk_sel_q)
			3'd1: tick = 1'b1;
			3'd2: tick = presc_q[2:0] == 3'h7;
			3'd3: tick = presc_q[5:0] == 6'h3F;
			3'd4: tick = presc_q[7:0] == 8'hFF;
			3'd5: tick = presc_q == 10'h3FF;
			default: tick = 1'b0;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			presc_q <= 10'h000;
		end else begin
			presc_q <= presc_q + 10'h001;
		end
	end

	// APB decode; one wait state per access phase
	logic acc, wr, rd;
	assign acc = psel && penable && !pready_q;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	logic hit;
	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			`TCM_ADDR_CTRL_A, `TCM_ADDR_CTRL_B, `TCM_ADDR_CMP_A, `TCM_ADDR_CMP_B,
			`TCM_ADDR_COUNT, `TCM_ADDR_STATUS, `TCM_ADDR_MASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_a_q <= `TCM_CTRL_A_RESET;
			wave_mode_high_q <= 1'b0;
			clk_sel_q <= 3'd0;
			mask_q <= '0;
		end else if (wr) begin
			if (paddr == `TCM_ADDR_CTRL_A) begin
				ctrl_a_q <= pwdata[7:0] & `TCM_CTRL_A_WMASK;
			end
			if (paddr == `TCM_ADDR_CTRL_B) begin
				wave_mode_high_q <= pwdata[3];
				clk_sel_q <= pwdata[2:0];
			end
			if (paddr == `TCM_ADDR_MASK) begin
				mask_q <= pwdata[`TCM_ST_W-1:0];
			end
		end
	end

	// Counter and direction
	logic at_top, at_bottom, write_count;
	assign at_top = count_q == top;
	assign at_bottom = count_q == `TCM_BOTTOM;
	assign write_count = wr && paddr == `TCM_ADDR_COUNT;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_q <= 8'h00;
			down_q <= 1'b0;
		end else if (write_count) begin
			count_q <= pwdata[7:0];
		end else if (tick) begin
			if (is_pc) begin
				if (!down_q && at_top) begin
					down_q <= 1'b1;
					count_q <= count_q - 8'h01;
				end else if (down_q && at_bottom) begin
					down_q <= 1'b0;
					count_q <= count_q + 8'h01;
				end else begin
					count_q <= down_q ? count_q - 8'h01 : count_q + 8'h01;
				end
			end else begin
				down_q <= 1'b0;
				count_q <= (at_top && mode != tcm_pkg::TCM_NORMAL) ? `TCM_BOTTOM : count_q + 8'h01;
			end
		end
	end

	// Compare buffers; double buffered only in PWM
	logic reload;
	assign reload = !is_pwm || (tick && (is_pc ? (at_top && !down_q) : at_top));
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmp_a_buf_q <= 8'h00;
			cmp_b_buf_q <= 8'h00;
		end else if (wr) begin
			if (paddr == `TCM_ADDR_CMP_A) cmp_a_buf_q <= pwdata[7:0];
			if (paddr == `TCM_ADDR_CMP_B) cmp_b_buf_q <= pwdata[7:0];
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmp_a_q <= 8'h00;
			cmp_b_q <= 8'h00;
		end else if (reload) begin
			cmp_a_q <= cmp_a_buf_q;
			cmp_b_q <= cmp_b_buf_q;
		end
	end

	// Events, evaluated at the count the tick leaves
	logic match_a, match_b, ovf;
	assign match_a = tick && count_q == cmp_a_q;
	assign match_b = tick && count_q == cmp_b_q;
	always_comb begin
		unique case (mode)
			tcm_pkg::TCM_PC_FF, tcm_pkg::TCM_PC_CA: ovf = tick && at_bottom && down_q;
			tcm_pkg::TCM_FAST_CA: ovf = tick && at_top;
			default: ovf = tick && count_q == `TCM_MAX;
		endcase
	end
	// Fast PWM restarts at BOTTOM on the tick leaving TOP
	logic fast_wrap;
	assign fast_wrap = is_fast && tick && at_top;

	// Waveform state per channel
	function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic match,
			input logic special, input logic chan_a);
		logic n;
		n = cur;
		if (!is_pwm) begin
			if (match) begin
				unique case (tcm_pkg::tcm_out_mode_e'(com))
					tcm_pkg::TCM_TOG: n = !cur;
					tcm_pkg::TCM_CLR: n = 1'b0;
					tcm_pkg::TCM_SET: n = 1'b1;
					tcm_pkg::TCM_OFF: n = cur;
				endcase
			end
		end else if (com == 2'b01) begin
			if (chan_a && wave_mode_high_q && match) n = !cur;
		end else if (com[1]) begin
			if (is_fast) begin
				if (fast_wrap) n = !com[0];
				else if (match && !special) n = com[0];
			end else if (special) begin
				if (tick && at_top && !down_q) n = com[0];
			end else if (match) begin
				n = down_q ? !com[0] : com[0];
			end
		end
		return n;
	endfunction

	logic sp_a, sp_b;
	assign sp_a = is_pwm && ctrl_a_q[7] && cmp_a_q == top;
	assign sp_b = is_pwm && ctrl_a_q[5] && cmp_b_q == top;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			oa_q <= 1'b0;
			ob_q <= 1'b0;
		end else begin
			oa_q <= wave_next(oa_q, ctrl_a_q[7:6], match_a, sp_a, 1'b1);
			ob_q <= wave_next(ob_q, ctrl_a_q[5:4], match_b, sp_b, 1'b0);
		end
	end

	// Pin drivers registered
	always_ff @(posedge core_clk) begin
		if (reset) begin
			chan_a_wave_out <= 1'b0;
			chan_a_wave_oe <= 1'b0;
			chan_a_pin_override <= 1'b0;
			chan_b_wave_out <= 1'b0;
			chan_b_wave_oe <= 1'b0;
			chan_b_pin_override <= 1'b0;
		end else begin
			chan_a_wave_out <= oa_q;
			chan_a_pin_override <= |ctrl_a_q[7:6];
			chan_a_wave_oe <= |ctrl_a_q[7:6] && dir_a_out;
			chan_b_wave_out <= ob_q;
			chan_b_pin_override <= |ctrl_a_q[5:4];
			chan_b_wave_oe <= |ctrl_a_q[5:4] && dir_b_out;
		end
	end

	// Sticky status, set wins over write-one-to-clear
	logic [`TCM_ST_W-1:0] ev, clr;
	assign ev = {match_b, match_a, ovf};
	assign clr = (wr && paddr == `TCM_ADDR_STATUS) ? pwdata[`TCM_ST_W-1:0] : '0;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			status_q <= '0;
			irq <= 1'b0;
		end else begin
			status_q <= (status_q & ~clr) | ev;
			irq <= |(((status_q & ~clr) | ev) & mask_q);
		end
	end

	// Read path
	always_comb begin
		prdata_q = 32'h0000_0000;
		unique case (paddr)
			`TCM_ADDR_CTRL_A: prdata_q = {24'h00_0000, ctrl_a_q};
			`TCM_ADDR_CTRL_B: prdata_q = {28'h000_0000, wave_mode_high_q, clk_sel_q};
			`TCM_ADDR_CMP_A: prdata_q = {24'h00_0000, cmp_a_buf_q};
			`TCM_ADDR_CMP_B: prdata_q = {24'h00_0000, cmp_b_buf_q};
			`TCM_ADDR_COUNT: prdata_q = {24'h00_0000, count_q};
			`TCM_ADDR_STATUS: prdata_q = {29'h0000_0000, status_q};
			`TCM_ADDR_MASK: prdata_q = {29'h0000_0000, mask_q};
			default: prdata_q = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pready_q <= 1'b0;
		end else begin
			pready <= acc;
			pready_q <= acc;
			pslverr <= acc && !hit;
			prdata <= rd ? prdata_q : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// [tcm_timer_assertions.sv]
`include "tcm_consts.svh"
`default_nettype none
module tcm_timer_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic dir_a_out,
	input wire logic dir_b_out,
	input wire logic chan_a_wave_oe,
	input wire logic chan_a_pin_override,
	input wire logic chan_b_wave_oe,
	input wire logic chan_b_pin_override
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	logic ctrl_wr;
	assign ctrl_wr = psel && penable && pwrite && !pready && paddr == `TCM_ADDR_CTRL_A;
	a_oe_a_dir: assert property (chan_a_wave_oe |-> $past(dir_a_out))
		else $error("A driver on without direction");
	a_oe_b_dir: assert property (chan_b_wave_oe |-> $past(dir_b_out))
		else $error("B driver on without direction");
	a_oe_a_ovr: assert property (chan_a_wave_oe |-> chan_a_pin_override)
		else $error("A driver on while disconnected");
	a_ovr_a_on: assert property (ctrl_wr && pwdata[7:6] != 2'b00 |-> ##[1:3] chan_a_pin_override)
		else $error("A pin not taken over");
	a_ovr_a_off: assert property (ctrl_wr && pwdata[7:6] == 2'b00 |-> ##[1:3] !chan_a_pin_override)
		else $error("A pin not released");
	a_ovr_b_on: assert property (ctrl_wr && pwdata[5:4] != 2'b00 |-> ##[1:3] chan_b_pin_override)
		else $error("B pin not taken over");
	a_ctrl_rsvd_zero: assert property (pready && !pwrite && paddr == `TCM_ADDR_CTRL_A |-> prdata[3:2] == 2'b00)
		else $error("Reserved control bits read nonzero");
	a_answer_one_wait: assert property (psel && penable && !pready |=> pready && $stable(paddr))
		else $error("Access not answered after one wait");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("Error response without ready");
endmodule
bind tcm_timer tcm_timer_assertions chk_i (.core_clk(core_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dir_a_out(dir_a_out), .dir_b_out(dir_b_out),
	.chan_a_wave_oe(chan_a_wave_oe), .chan_a_pin_override(chan_a_pin_override),
	.chan_b_wave_oe(chan_b_wave_oe), .chan_b_pin_override(chan_b_pin_override));
`default_nettype wire

// [tcm_timer_tb.sv]
`include "tcm_consts.svh"
`default_nettype none
module tcm_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic dir_a_out = 1'b1;
	logic dir_b_out = 1'b1;
	logic [31:0] prdata;
	logic pready, pslverr, wa, oea, ova, wb, oeb, ovb, irq;
	int num_errors = 0;
	int checks = 0;
	logic [32:0] exp_q[$];
	logic [31:0] seed = 32'h0000_10c9;
	always #20 core_clk = ~core_clk;
	tcm_timer dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dir_a_out(dir_a_out), .dir_b_out(dir_b_out), .chan_a_wave_out(wa), .chan_a_wave_oe(oea),
		.chan_a_pin_override(ova), .chan_b_wave_out(wb), .chan_b_wave_oe(oeb),
		.chan_b_pin_override(ovb), .irq(irq));
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Ready is judged as it stands before the edge, not after the slave updates it
		@(posedge core_clk iff (pready === 1'b1));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [11:0] a, input int d);
		apb(1'b1, a, 32'(d), 33'h0_0000_0000);
	endtask
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Every answered access retires the oldest noted result
	always @(posedge core_clk)
		if (pready === 1'b1 && exp_q.size() > 0)
			chk({pslverr, prdata}, exp_q.pop_front());
	task automatic measure(input int win, input int hi);
		int ha;
		int hb;
		ha = 0;
		hb = 0;
		repeat (win) begin
			@(posedge core_clk);
			ha += (wa === 1'b1);
			hb += (wb === 1'b1);
		end
		chk(33'(ha), 33'(hi));
		chk(33'(hb), 33'(hi));
	endtask
	initial begin
		int mode[5] = '{2, 3, 3, 1, 1};
		int code[5] = '{1, 2, 3, 2, 3};
		int r;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, `TCM_ADDR_CTRL_A, 0, 33'h0_0000_0000);
		wr(`TCM_ADDR_CTRL_A, 243);
		apb(1'b0, `TCM_ADDR_CTRL_A, 0, 33'h0_0000_00F3);
		apb(1'b0, 12'h100, 0, 33'h1_0000_0000);
		$display("Done: registers");
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			r = (mode[i] == 3) ? 1 + int'(seed % 200) : (mode[i] == 2 ? 9 : 64);
			wr(`TCM_ADDR_CTRL_B, 0);
			wr(`TCM_ADDR_COUNT, 0);
			wr(`TCM_ADDR_CMP_A, r);
			wr(`TCM_ADDR_CMP_B, r);
			wr(`TCM_ADDR_CTRL_B, (mode[i] / 4) * 8 + 1);
			wr(`TCM_ADDR_CTRL_A, code[i] * 80 + mode[i] % 4);
			// Long settle so buffered compares have reloaded
			repeat (600) @(posedge core_clk);
			if (mode[i] == 2)
				measure(200, 100);
			else if (mode[i] == 3)
				measure(256, code[i] == 2 ? r + 1 : 255 - r);
			else
				measure(510, code[i] == 2 ? 128 : 382);
		end
		$display("Done: waveforms");
		dir_a_out <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(33'(oea), 33'h0_0000_0000);
		chk(33'(ova), 33'h0_0000_0001);
		dir_a_out <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(33'(oea), 33'h0_0000_0001);
		$display("Done: pin drivers");
		wr(`TCM_ADDR_CTRL_B, 0);
		wr(`TCM_ADDR_CTRL_A, 0);
		wr(`TCM_ADDR_MASK, 0);
		wr(`TCM_ADDR_STATUS, 7);
		wr(`TCM_ADDR_CTRL_B, 1);
		repeat (300) @(posedge core_clk);
		chk(33'(irq), 33'h0_0000_0000);
		wr(`TCM_ADDR_MASK, 1);
		repeat (3) @(posedge core_clk);
		chk(33'(irq), 33'h0_0000_0001);
		wr(`TCM_ADDR_CTRL_B, 0);
		wr(`TCM_ADDR_STATUS, 7);
		repeat (3) @(posedge core_clk);
		chk(33'(irq), 33'h0_0000_0000);
		$display("Done: interrupt");
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		$display("Error at %0t: timeout", $time);
		end_of_test();
	end
endmodule
`default_nettype wire
